//--- hdl/eir_pkg.sv
// Purpose: Constants and types for the external line source and remap block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: One aligned word per register
// How it works
// - Four-bit field picks port A..G pin with the line's own index.
// - Word 0x0c holds line 4..7 fields from bit 0; upper half reserved.
// - Word 0x10 holds line 8..11 fields, line 8 lowest nibble.
// - Word 0x14 holds line 12..15 fields, line 12 lowest nibble.
// - Remap word 0x1c resets to zero; bits 4:0 and 9:8 writable, 13:10 only in high density.
// - Misc bit clear: fifth channel shares vector 59; set: own 60.
// - Misc bit picks DAC trigger 3 and timer 1/3 trigger: 5 or 15.
// - Misc, timer 12 and address-valid bits exist only in high density.
// - Bit 12 moves timer 12 channels from PC4/PC5 to PB12/PB13.
// - Bit 11 moves basic timer DMA requests from controller 2 to 1.
// - Bit 10 set disconnects the address-valid output from its pin.
// - Bit 9 moves timer 14 channel 1 from PC9 to PB1.
// - Bit 8 moves timer 13 channel 1 from PC8 to PB0.
// - Bit 4 moves timer 1 ch1/ch2 DMA from channels 2/3 to 6.
// - Bit 3 moves the CEC line from PB8 to PB10.
// - Bit 2 moves timer 17 channel 1 from PB9 to PA7.
// - Bit 1 moves timer 16 channel 1 from PB8 to PA6.
// - Bit 0 moves timer 15 channels from PA2/PA3 to PB14/PB15.
// - Word 0x08 holds line 0..3 fields with the same encoding.
package eir_pkg;
	localparam logic [7:0] ADR_SRC_0_3 = 8'h08;
	localparam logic [7:0] ADR_SRC_4_7 = 8'h0c;
	localparam logic [7:0] ADR_SRC_8_11 = 8'h10;
	localparam logic [7:0] ADR_SRC_12_15 = 8'h14;
	localparam logic [7:0] ADR_REMAP = 8'h1c;
	localparam int NUM_LINES = 16;
	localparam int NUM_PORTS = 7;
	localparam int FLD_W = 4;
	localparam logic [3:0] PORT_LAST = 4'h6;
	localparam logic [15:0] SRC_RESET = 16'h0000;
	localparam logic [13:0] REMAP_RESET = 14'h0000;
	// Writable remap bits, low and high density
	localparam logic [13:0] REMAP_MASK_LD = 14'h031f;
	localparam logic [13:0] REMAP_MASK_HD = 14'h3f1f;
	localparam int B_T15 = 0;
	localparam int B_T16 = 1;
	localparam int B_T17 = 2;
	localparam int B_CEC = 3;
	localparam int B_T1DMA = 4;
	localparam int B_T13 = 8;
	localparam int B_T14 = 9;
	localparam int B_ADDRESS_VALID_OUT = 10;
	localparam int B_BTDMA = 11;
	localparam int B_T12 = 12;
	localparam int B_MISC = 13;
	localparam logic [6:0] VEC_SHARED = 7'd59;
	localparam logic [6:0] VEC_OWN = 7'd60;
	localparam logic [2:0] DAC_TRIG3_CODE = 3'h3;
	localparam logic [1:0] DMA_CH2 = 2'h0;
	localparam logic [1:0] DMA_CH3 = 2'h1;
	localparam logic [1:0] DMA_CH6 = 2'h2;

	typedef struct packed {
		logic [3:0][15:0] src;
		logic [13:0] remap;
		logic ack;
		logic [31:0] dat;
	} eir_state_s;

	typedef struct packed {
		logic [6:0] dma2_ch5_vector;
		logic trig_from_t15;
		logic [1:0] t1_ch1_dma_chan;
		logic [1:0] t1_ch2_dma_chan;
		logic basic_dma_on_ctl1;
	} eir_route_s;
endpackage : eir_pkg

//--- hdl/eir_remap.sv
// Purpose: External line source select and secondary signal remap
// Assumes: Inputs synchronous to clk_i; master holds request until ack
// Notes: Ack comes one cycle after the request is seen
`timescale 1ns/1ps
module eir_remap #(
	parameter bit HIGH_DENSITY = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Port pin levels, one vector per port A..G
	input wire logic [6:0][15:0] port_pins_i,
	// Selected external line levels
	output logic [15:0] ext_line_o,
	// Pin moves and routing
	output logic timer_fifteen_pin_move_o,
	output logic timer_sixteen_pin_move_o,
	output logic timer_seventeen_pin_move_o,
	output logic cec_pin_move_o,
	output logic adv_timer_dma_route_o,
	output logic timer_thirteen_pin_move_o,
	output logic timer_fourteen_pin_move_o,
	output logic addr_valid_disconnect_o,
	output logic basic_timer_dma_route_o,
	output logic timer_twelve_pin_move_o,
	output logic misc_remap_o,
	output eir_pkg::eir_route_s route_o,
	// Memory controller address-valid path
	input wire logic address_valid_out_i,
	output logic address_valid_pin_o,
	output logic address_valid_pin_oe_n_o
);
	eir_pkg::eir_state_s st_ff;
	eir_pkg::eir_state_s nxt_st;
	logic req;
	logic [31:0] wmask;
	logic [31:0] rd;
	logic [13:0] rmask;

	assign req = cyc_i && stb_i && !st_ff.ack;
	assign rmask = HIGH_DENSITY ? eir_pkg::REMAP_MASK_HD : eir_pkg::REMAP_MASK_LD;

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{sel_i[b]}};
		end
		rd = 32'h0000_0000;
		unique case (adr_i)
			eir_pkg::ADR_SRC_0_3: rd = {16'h0000, st_ff.src[0]};
			eir_pkg::ADR_SRC_4_7: rd = {16'h0000, st_ff.src[1]};
			eir_pkg::ADR_SRC_8_11: rd = {16'h0000, st_ff.src[2]};
			eir_pkg::ADR_SRC_12_15: rd = {16'h0000, st_ff.src[3]};
			eir_pkg::ADR_REMAP: rd = {18'h00000, st_ff.remap};
			default: rd = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// Register state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = req;
		if (req) begin
			nxt_st.dat = rd;
		end
		if (req && we_i) begin
			for (int r = 0; r < 4; r++) begin
				if (adr_i == eir_pkg::ADR_SRC_0_3 + 8'(r * 4)) begin
					nxt_st.src[r] = (st_ff.src[r] & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
				end
			end
			if (adr_i == eir_pkg::ADR_REMAP) begin
				nxt_st.remap = ((st_ff.remap & ~wmask[13:0]) | (dat_i[13:0] & wmask[13:0]))
					& rmask;
			end
		end
		if (rst_i) begin
			nxt_st.src = {4{eir_pkg::SRC_RESET}};
			nxt_st.remap = eir_pkg::REMAP_RESET;
			nxt_st.ack = 1'b0;
			nxt_st.dat = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
	end

	assign ack_o = st_ff.ack;
	assign dat_o = st_ff.dat;

	// ==========================================================
	// Line source muxes
	for (genvar l = 0; l < eir_pkg::NUM_LINES; l++) begin : g_line
		logic [3:0] code;
		assign code = st_ff.src[l / 4][(l % 4) * eir_pkg::FLD_W +: eir_pkg::FLD_W];
		// Codes above port G give a quiet zero
		assign ext_line_o[l] = (code <= eir_pkg::PORT_LAST)
			? port_pins_i[code[2:0]][l] : 1'b0;
	end

	// ==========================================================
	// Remap outputs
	assign timer_fifteen_pin_move_o = st_ff.remap[eir_pkg::B_T15];
	assign timer_sixteen_pin_move_o = st_ff.remap[eir_pkg::B_T16];
	assign timer_seventeen_pin_move_o = st_ff.remap[eir_pkg::B_T17];
	assign cec_pin_move_o = st_ff.remap[eir_pkg::B_CEC];
	assign adv_timer_dma_route_o = st_ff.remap[eir_pkg::B_T1DMA];
	assign timer_thirteen_pin_move_o = st_ff.remap[eir_pkg::B_T13];
	assign timer_fourteen_pin_move_o = st_ff.remap[eir_pkg::B_T14];
	assign addr_valid_disconnect_o = st_ff.remap[eir_pkg::B_ADDRESS_VALID_OUT];
	assign basic_timer_dma_route_o = st_ff.remap[eir_pkg::B_BTDMA];
	assign timer_twelve_pin_move_o = st_ff.remap[eir_pkg::B_T12];
	assign misc_remap_o = st_ff.remap[eir_pkg::B_MISC];

	always_comb begin
		route_o.dma2_ch5_vector = misc_remap_o ? eir_pkg::VEC_OWN : eir_pkg::VEC_SHARED;
		route_o.trig_from_t15 = misc_remap_o;
		route_o.t1_ch1_dma_chan = adv_timer_dma_route_o ? eir_pkg::DMA_CH6 : eir_pkg::DMA_CH2;
		route_o.t1_ch2_dma_chan = adv_timer_dma_route_o ? eir_pkg::DMA_CH6 : eir_pkg::DMA_CH3;
		route_o.basic_dma_on_ctl1 = basic_timer_dma_route_o;
	end

	// Pin released when disconnected; enable is active low
	assign address_valid_pin_o = address_valid_out_i;
	assign address_valid_pin_oe_n_o = addr_valid_disconnect_o;

	// ==========================================================
	// Checks
	chk_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
		(req |=> ack_o) and (ack_o |=> !ack_o)) else $error("ack timing wrong");
	chk_remap_reset_zero: assert property (@(posedge clk_i)
		rst_i |=> st_ff.remap == eir_pkg::REMAP_RESET) else $error("remap not reset");
	chk_src_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && we_i && adr_i == eir_pkg::ADR_SRC_4_7 && sel_i == 4'hf)
		|=> st_ff.src[1] == $past(dat_i[15:0])) else $error("line 4..7 write lost");
	chk_read_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |-> dat_o[31:16] == 16'h0000) else $error("reserved bits nonzero");
	chk_vector_pick: assert property (@(posedge clk_i) disable iff (rst_i)
		route_o.dma2_ch5_vector == (st_ff.remap[eir_pkg::B_MISC] ? 7'd60 : 7'd59))
		else $error("vector position wrong");
	chk_low_density_bits: assert property (@(posedge clk_i) disable iff (rst_i)
		!HIGH_DENSITY |-> st_ff.remap[13:10] == 4'h0) else $error("hd bit in ld part");
	chk_line_zero_pick: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_ff.src[0][3:0] == 4'h1) |-> ext_line_o[0] == port_pins_i[1][0])
		else $error("line 0 source wrong");
	chk_bad_code_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_ff.src[3][15:12] > 4'h6) |-> !ext_line_o[15]) else $error("bad code drives");
	chk_address_valid_out_release: assert property (@(posedge clk_i) disable iff (rst_i)
		address_valid_pin_oe_n_o == st_ff.remap[eir_pkg::B_ADDRESS_VALID_OUT]) else $error("address_valid_out pin");
	chk_dma_route: assert property (@(posedge clk_i) disable iff (rst_i)
		adv_timer_dma_route_o |-> route_o.t1_ch2_dma_chan == eir_pkg::DMA_CH6)
		else $error("dma route wrong");
endmodule : eir_remap

//--- tb/testbench.sv
// Purpose: Self-checking bench for the line source and remap block
// Assumes: Classic Wishbone, one-cycle ack, high-density build
// Notes: Row table for register accesses, hand tests after it
`timescale 1ns/1ps
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic ack_o;
	logic av_i = 1'b0;
	logic av_o;
	logic av_oe_n;
	logic [6:0][15:0] pins = '0;
	logic [15:0] lines;
	logic [10:0] mv;
	eir_pkg::eir_route_s route;
	int bad_count = 0;
	int n_checks = 0;
	int cyc_cnt = 0;
	typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r;} eir_row_s;
	eir_row_s rows [6] = '{'{8'h08, 32'h0000_4561, 32'h0000_4561},
		'{8'h0c, 32'hffff_6543, 32'h0000_6543}, '{8'h10, 32'habcd_7f06, 32'h0000_7f06},
		'{8'h14, 32'h0000_8123, 32'h0000_8123}, '{8'h1c, 32'hffff_ffff, 32'h0000_3f1f},
		'{8'h18, 32'hffff_ffff, 32'h0000_0000}};

	eir_remap i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.port_pins_i(pins), .ext_line_o(lines), .timer_fifteen_pin_move_o(mv[0]),
		.timer_sixteen_pin_move_o(mv[1]), .timer_seventeen_pin_move_o(mv[2]),
		.cec_pin_move_o(mv[3]), .adv_timer_dma_route_o(mv[4]),
		.timer_thirteen_pin_move_o(mv[5]), .timer_fourteen_pin_move_o(mv[6]),
		.addr_valid_disconnect_o(mv[7]), .basic_timer_dma_route_o(mv[8]),
		.timer_twelve_pin_move_o(mv[9]), .misc_remap_o(mv[10]), .route_o(route),
		.address_valid_out_i(av_i), .address_valid_pin_o(av_o),
		.address_valid_pin_oe_n_o(av_oe_n));

	// ==========
	// Clock, timeout and helpers
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			bad_count++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'b00;
	endtask : wb
	task chk_lines(input logic [3:0][15:0] src);
		logic [15:0] e;
		logic [3:0] c;
		for (int x = 0; x < 16; x++) begin
			c = src[x / 4][(x % 4) * 4 +: 4];
			e[x] = (c <= 4'h6) ? pins[c[2:0]][x] : 1'b0;
		end
		chk({16'h0, lines}, {16'h0, e});
	endtask : chk_lines

	// ==========
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({25'h0, route.dma2_ch5_vector}, {25'h0, eir_pkg::VEC_SHARED});
		chk({30'h0, route.t1_ch1_dma_chan}, {30'h0, eir_pkg::DMA_CH2});
		chk({30'h0, route.t1_ch2_dma_chan}, {30'h0, eir_pkg::DMA_CH3});
		chk({19'h0, route.trig_from_t15, route.basic_dma_on_ctl1, mv}, 32'h0);
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, rows[i].a, 4'hf, 32'h0);
			chk(rd, 32'h0);
		end
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, rows[i].a, 4'hf, rows[i].w);
			wb(1'b0, rows[i].a, 4'hf, 32'h0);
			chk(rd, rows[i].r);
		end
		chk({21'h0, mv}, 32'h7ff);
		chk({25'h0, route.dma2_ch5_vector}, {25'h0, eir_pkg::VEC_OWN});
		chk({30'h0, route.t1_ch1_dma_chan}, {30'h0, eir_pkg::DMA_CH6});
		chk({30'h0, route.t1_ch2_dma_chan}, {30'h0, eir_pkg::DMA_CH6});
		chk({30'h0, route.trig_from_t15, route.basic_dma_on_ctl1}, 32'h3);
		chk({31'h0, av_oe_n}, 32'h1);
		for (int p = 0; p < 7; p++)
			pins[p] <= 16'ha5c3 ^ (16'h1111 * p[15:0]);
		repeat (2) @(posedge clk_i);
		chk_lines({16'h8123, 16'h7f06, 16'h6543, 16'h4561});
		pins <= ~pins;
		av_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk_lines({16'h8123, 16'h7f06, 16'h6543, 16'h4561});
		// Low byte lane only: upper remap bits must survive
		wb(1'b1, 8'h1c, 4'h1, 32'h0);
		wb(1'b0, 8'h1c, 4'hf, 32'h0);
		chk(rd, 32'h3f00);
		chk({21'h0, mv}, 32'h7e0);
		wb(1'b1, 8'h1c, 4'hf, 32'h0);
		@(posedge clk_i);
		chk({30'h0, av_o, av_oe_n}, 32'h2);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h14, 4'hf, 32'h0);
		chk(rd, 32'h0);
		end_of_test();
	end
endmodule : testbench
